// [wave_meas_map.svh]
// Offsets, field positions and reset values of the wave measurement timer.
`ifndef WAVE_MEAS_MAP_SVH
`define WAVE_MEAS_MAP_SVH
`define WM_ADDR_CTRL    4'h0
`define WM_ADDR_LATCH   4'h4
`define WM_ADDR_COUNT   4'h8
`define WM_ADDR_STATUS  4'hC
`define WM_ADDR_MASK    4'h1
`define WM_ADDR_MASK_HI 4'h1
`define WM_BIT_MEAS     3
`define WM_BIT_CMPTYPE  4
`define WM_BIT_POL      5
`define WM_BIT_OUTEN    7
`define WM_BIT_RESET    0
`define WM_ST_FLAG      0
`define WM_ST_EXPIRY    1
`define WM_CTRL_RESET   8'h01
`define WM_LATCH_RESET  16'hFFFF
`define WM_MASK_RESET   2'h0
`endif

// [wave_meas_pkg.sv]
// Types shared by the wave measurement timer files.
package wave_meas_pkg;
  typedef enum logic [1:0] {
    MODE_FREQ_CLR  = 2'b00,
    MODE_FREQ_SET  = 2'b01,
    MODE_PULSE_CLR = 2'b10,
    MODE_PULSE_SET = 2'b11
  } meas_mode_e;
  typedef logic [15:0] count_t;
endpackage

// [gate_sync.sv]
// Gate input synchroniser with edge detection.
`timescale 1ns/100ps
`default_nettype none
module gate_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic gate_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta;
  logic sync;
  logic prev;

  // Two flops catch the gate, a third remembers the old level.
  // They reset to the idle high level so that no false edge follows reset.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end
    else
    begin
      meta <= gate_i;
      sync <= meta;
      prev <= sync;
    end
  end

  // Edges come from the settled level only.
  assign level_o = sync;
  assign rise_o  = sync & ~prev;
  assign fall_o  = ~sync & prev;
endmodule // gate_sync
`default_nettype wire

// [timer_wave_measurement.sv]
// Wave measurement channel of a programmable timer with a Wishbone slave.
//
// Overview of operation
// - Freq mode, polarity set: gate fall before expiry, no flag, restarts count.
// - Period check repeats each gate cycle until mode change or overlong cycle.
// - Compare type bit one: pulse width mode; rising gate ends the count.
// - Pulse mode, polarity clear: flag when low interval ends before expiry.
// - Pulse mode, polarity set: flag when expiry comes before gate rises.
// - Pulse mode: rising gate stops and holds counter for software to read.
// - Freq, polarity set: early expiry flags, stops; restart needs clear and fall.
// - Freq, polarity clear: second fall flags; first expiry recycles, blocks flags.
// - Output low until first expiry, then high, then toggles each expiry.
`timescale 1ns/100ps
`default_nettype none
`include "wave_meas_map.svh"
module timer_wave_measurement
  import wave_meas_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        gate_i,
  output logic             timer_out_pin_o,
  output logic             irq_o
);
  logic [7:0]  ctrl;
  count_t      latch;
  count_t      counter;
  logic        count_en;
  logic        flag;
  logic        expiry_sticky;
  logic [1:0]  mask;
  logic        blocked;
  logic        expired_once;
  logic        gate_lvl;
  logic        gate_rise;
  logic        gate_fall;
  logic        req;
  logic        wr;
  logic        latch_wr;
  logic        timer_reset;
  logic        measuring;
  logic        count_expiry;
  logic        init;
  logic        flag_set;
  logic        ce_set;
  logic        ce_clr;
  meas_mode_e  mode;

  // Decodes one word address of the register map.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Gate conditioning.
  // Synchronised gate edges.
  gate_sync u_gate_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .gate_i  (gate_i),
    .level_o (gate_lvl),
    .rise_o  (gate_rise),
    .fall_o  (gate_fall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode and mode selection.
  assign req         = cyc_i & stb_i & ~ack_o;
  assign wr          = req & we_i & sel_i[0];
  assign latch_wr    = wr & hit(adr_i, `WM_ADDR_LATCH);
  assign timer_reset = ctrl[`WM_BIT_RESET];
  assign measuring   = ctrl[`WM_BIT_MEAS];
  assign mode = meas_mode_e'({ctrl[`WM_BIT_CMPTYPE], ctrl[`WM_BIT_POL]});
  assign count_expiry = count_en & (counter == 16'h0000);

  // Counter initialisation, enable and flag conditions per mode.
  always_comb
  begin
    init     = timer_reset;
    flag_set = 1'b0;
    ce_clr   = latch_wr | timer_reset | flag;
    ce_set   = 1'b0;
    if (measuring)
    begin
      unique case (mode)
        MODE_FREQ_CLR:
        begin
          // Fall while counting flags unless first expiry blocked it.
          init     = init | (gate_fall & ~flag & (~count_en | expired_once));
          flag_set = gate_fall & count_en & ~blocked & ~expired_once;
        end
        MODE_FREQ_SET:
        begin
          // Fall with no flag restarts the count.
          init     = init | (gate_fall & ~flag);
          flag_set = count_expiry & ~expired_once;
        end
        MODE_PULSE_CLR:
        begin
          init     = init | (gate_fall & ~flag);
          flag_set = gate_rise & count_en & ~expired_once;
        end
        MODE_PULSE_SET:
        begin
          init     = init | (gate_fall & ~flag);
          flag_set = count_expiry & ~expired_once & ~gate_lvl;
        end
      endcase
      ce_set = gate_fall & ~flag & ~latch_wr & ~timer_reset;
      if (ctrl[`WM_BIT_CMPTYPE])
        ce_clr = ce_clr | gate_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control, latch and mask registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl  <= `WM_CTRL_RESET;
      latch <= `WM_LATCH_RESET;
      mask  <= `WM_MASK_RESET;
    end
    else if (wr)
    begin
      if (hit(adr_i, `WM_ADDR_CTRL))
        ctrl <= dat_i[7:0];
      if (latch_wr)
        latch <= {sel_i[1] ? dat_i[15:8] : latch[15:8], dat_i[7:0]};
      if (hit(adr_i, `WM_ADDR_MASK))
        mask <= dat_i[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter and count enable.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      counter      <= `WM_LATCH_RESET;
      count_en     <= 1'b0;
      expired_once <= 1'b0;
    end
    else
    begin
      if (ce_clr)
        count_en <= 1'b0;
      else if (ce_set)
        count_en <= 1'b1;
      if (init)
      begin
        counter      <= latch;
        expired_once <= 1'b0;
      end
      else if (count_expiry)
      begin
        counter      <= latch;
        expired_once <= 1'b1;
      end
      else if (count_en & ~ce_clr)
        counter <= counter - 16'h0001;
    end
  end

  // Block further flags after first expiry in freq mode, polarity clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i | init)
      blocked <= 1'b0;
    else if (count_expiry & (mode == MODE_FREQ_CLR))
      blocked <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status flags, cleared by writing one; a set wins.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag          <= 1'b0;
      expiry_sticky <= 1'b0;
    end
    else
    begin
      if (flag_set)
        flag <= 1'b1;
      else if (wr & hit(adr_i, `WM_ADDR_STATUS) & dat_i[`WM_ST_FLAG])
        flag <= 1'b0;
      if (count_expiry)
        expiry_sticky <= 1'b1;
      else if (wr & hit(adr_i, `WM_ADDR_STATUS) & dat_i[`WM_ST_EXPIRY])
        expiry_sticky <= 1'b0;
    end
  end

  // Interrupt output from unmasked status.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |({expiry_sticky, flag} & mask);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timer output.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      timer_out_pin_o <= 1'b0;
    // Low at init, toggles on expiry.
    else if (~ctrl[`WM_BIT_OUTEN] | init)
      timer_out_pin_o <= 1'b0;
    else if (count_expiry)
      timer_out_pin_o <= ~timer_out_pin_o;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus answer: one registered ack a cycle after the request, zero for unmapped reads.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= 32'h0000_0000;
      if (req & ~we_i)
      begin
        if (hit(adr_i, `WM_ADDR_CTRL))
          dat_o <= {24'h000000, ctrl};
        else if (hit(adr_i, `WM_ADDR_MASK))
          dat_o <= {30'h00000000, mask};
        else if (hit(adr_i, `WM_ADDR_LATCH))
          dat_o <= {16'h0000, latch};
        else if (hit(adr_i, `WM_ADDR_COUNT))
          dat_o <= {16'h0000, counter};
        else if (hit(adr_i, `WM_ADDR_STATUS))
          dat_o <= {29'h00000000, count_en, expiry_sticky, flag};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  flag_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (measuring && mode == MODE_PULSE_CLR && gate_rise && count_en
     && !expired_once) |=> flag) else $error("pulse flag missed");
  flag_exp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (measuring && mode == MODE_PULSE_SET && count_expiry && !expired_once
     && !gate_lvl) |=> flag) else $error("expiry flag missed");
  hold_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (measuring && ctrl[`WM_BIT_CMPTYPE] && gate_lvl && !init)
    |=> !count_en) else $error("pulse count not held");
  ce_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    latch_wr |=> !count_en) else $error("enable kept on latch write");
  restart_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (measuring && mode == MODE_FREQ_SET && gate_fall && !flag && !timer_reset)
    |=> counter == latch) else $error("no restart");
  stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag && !ce_set) |=> !count_en) else $error("counter ran");
  block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (measuring && mode == MODE_FREQ_CLR && expired_once && !init)
    |-> !flag_set) else $error("flag after block");
  out_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    init |=> !timer_out_pin_o) else $error("output not low");
  sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
    gate_rise |-> gate_lvl ##1 !gate_rise) else $error("bad edge");
  repeat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (measuring && mode == MODE_FREQ_SET && gate_fall && !flag)
    |-> !flag_set || count_expiry) else $error("spurious flag");
  pulse_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (measuring && mode[1] && gate_fall) |-> !flag_set)
    else $error("fall ended pulse count");
endmodule // timer_wave_measurement
`default_nettype wire

// [gate_model.sv]
// Behavioural source of the external gate waveform being measured.
`timescale 1ns/100ps
`default_nettype none
module gate_model
(
  input  wire logic clk_i,
  output logic      gate_o
);
  // The gate rests high between measured pulses.
  initial gate_o = 1'b1;

  // One low interval, then one high interval, counted in clock cycles.
  task automatic pulse(input int low_n, input int high_n);
    @(posedge clk_i);
    gate_o <= 1'b0;
    repeat (low_n) @(posedge clk_i);
    gate_o <= 1'b1;
    repeat (high_n) @(posedge clk_i);
  endtask
endmodule // gate_model
`default_nettype wire

// [tb_timer_wave_measurement.sv]
// Self-checking bench of the wave measurement timer channel.
`timescale 1ns/100ps
`default_nettype none
`include "wave_meas_map.svh"
module tb_timer_wave_measurement;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [3:0]  adr_i = 4'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        gate;
  logic        out_pin;
  logic        irq_o;
  logic [31:0] q;
  logic [31:0] c1;
  int          n_fail = 0;
  int          tests_run = 0;

  // The clock toggles every half period of 5 ns.
  always #5 clk_i = ~clk_i;

  timer_wave_measurement dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .gate_i(gate), .timer_out_pin_o(out_pin),
    .irq_o(irq_o));
  gate_model gate_u (.clk_i(clk_i), .gate_o(gate));

  ////////////////////////////////////////////////////////////////////////////
  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Park the channel, load the latch, clear status, then release the mode.
  task automatic setup(input logic [7:0] c, input logic [15:0] l);
    wb(1'b1, `WM_ADDR_CTRL, {24'h0, c | 8'h01});
    wb(1'b1, `WM_ADDR_LATCH, {16'h0, l});
    wb(1'b1, `WM_ADDR_STATUS, 32'h3);
    wb(1'b1, `WM_ADDR_CTRL, {24'h0, c});
  endtask

  // Read status and compare the flag and count enable bits.
  task automatic stat(input string nm, input logic f, input logic en);
    wb(1'b0, `WM_ADDR_STATUS, 32'h0);
    chk(nm, {29'h0, en, 1'b0, f}, q & 32'h5);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wb(1'b0, `WM_ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h01, q);
    wb(1'b0, `WM_ADDR_MASK_HI, 32'h0);
    chk("mask", 32'h0, q);
    wb(1'b0, `WM_ADDR_COUNT, 32'h0);
    chk("count", 32'hFFFF, q);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("irq", 32'h0, {31'h0, irq_o});
    $display("Done reset");
  endtask

  task automatic t_pulse_clr();
    setup(8'h18, 16'h0064);
    gate_u.pulse(30, 20);
    stat("pw flag", 1'b1, 1'b0);
    wb(1'b0, `WM_ADDR_COUNT, 32'h0);
    c1 = q;
    wb(1'b0, `WM_ADDR_COUNT, 32'h0);
    chk("held count", c1, q);
    chk("width", 32'h1, {31'h0, (c1 > 32'd55 && c1 < 32'd100)});
    wb(1'b1, `WM_ADDR_MASK_HI, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq on", 32'h1, {31'h0, irq_o});
    wb(1'b1, `WM_ADDR_MASK_HI, 32'h0);
    repeat (2) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(1'b1, `WM_ADDR_MASK_HI, 32'h1);
    wb(1'b1, `WM_ADDR_STATUS, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    setup(8'h18, 16'h0064);
    gate_u.pulse(150, 10);
    stat("pw long", 1'b0, 1'b0);
    $display("Done pulse width, polarity clear");
  endtask

  task automatic t_pulse_set();
    setup(8'h38, 16'h0014);
    gate_u.pulse(10, 10);
    stat("pw short", 1'b0, 1'b0);
    gate_u.pulse(60, 10);
    stat("pw long", 1'b1, 1'b0);
    $display("Done pulse width, polarity set");
  endtask

  task automatic t_freq_clr();
    setup(8'h08, 16'h0064);
    gate_u.pulse(20, 20);
    gate_u.pulse(20, 20);
    stat("fc short", 1'b1, 1'b0);
    setup(8'h08, 16'h0064);
    gate_u.pulse(20, 130);
    gate_u.pulse(20, 20);
    wb(1'b0, `WM_ADDR_STATUS, 32'h0);
    chk("fc blocked", 32'h0, q & 32'h1);
    $display("Done frequency, polarity clear");
  endtask

  task automatic t_freq_set();
    setup(8'hA8, 16'h0064);
    chk("out init", 32'h0, {31'h0, out_pin});
    repeat (3) gate_u.pulse(20, 20);
    wb(1'b0, `WM_ADDR_STATUS, 32'h0);
    chk("fs repeat", 32'h0, q & 32'h1);
    chk("out low", 32'h0, {31'h0, out_pin});
    gate_u.pulse(20, 180);
    stat("fs long", 1'b1, 1'b0);
    chk("out high", 32'h1, {31'h0, out_pin});
    wb(1'b0, `WM_ADDR_COUNT, 32'h0);
    c1 = q;
    wb(1'b0, `WM_ADDR_COUNT, 32'h0);
    chk("fs stopped", c1, q);
    wb(1'b1, `WM_ADDR_STATUS, 32'h3);
    gate_u.pulse(20, 20);
    stat("fs restart", 1'b0, 1'b1);
    $display("Done frequency, polarity set");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence: hold reset for 12 cycles, then run each scenario.
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pulse_clr();
    t_pulse_set();
    t_freq_clr();
    t_freq_set();
    complete_run();
  end

  // Watchdog cuts a hang short well after the expected run length.
  initial
  begin
    repeat (30000) @(posedge clk_i);
    n_fail++;
    $display("Watchdog expired");
    complete_run();
  end
endmodule // tb_timer_wave_measurement
`default_nettype wire
